// *** beat_timer.sv ***
// down-counter that times access latency for the controller
module beat_timer
  import mc_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  beat_timer_if.tmr    t
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // last flags the final wait cycle so the next state can start the beat
  assign t.last = (cnt_q == CNT_W'(1));

  always_comb
  begin
    cnt_d = cnt_q;
    if (t.load)
    begin
      cnt_d = t.len;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** beat_timer_if.sv ***
// link between the controller sequencer and its cycle timer
interface beat_timer_if;
  import mc_pkg::*;

  logic             load;
  logic [CNT_W-1:0] len;
  logic             last;

  modport ctrl (output load, output len, input last);
  modport tmr  (input load, input len, output last);
endinterface

// *** burst_sram_memory_controller.sv ***
// fixed-map memory controller for burst sram, flash and i/o on a split-tenure bus
//
// Notes on behaviour
// R1 - all regions are 64 bits wide; no lane steering, no split cycles
// R2 - lowest quarter, code 00, is sram; bursts 3-1-1-1
// R3 - second quarter is fast i/o, single beat, 4 cycles
// R4 - third quarter is slow i/o, single beat, 12 cycles
// R5 - top quarter is flash, single beat, 6 cycles
// R6 - every sram transfer drives the full sram strobe set
// R7 - address strobe latches the address for single and burst
// R8 - chip enable and address strobe together, one clock after start
// R9 - two low word-address lines carry burst start position
// R10 - writes assert active-low byte enables for the addressed lanes
// R11 - reads assert output enable; all lanes driven
// R12 - burst advance low three cycles in a burst, high otherwise
// R13 - no throttling, no extra delay after the address strobe
// R14 - no overlapped tenures; each transfer starts a fresh access
// R15 - deselect cycle after every sram access
// R16 - deselect is address strobe with chip enable negated
// R17 - start on transfer start; region from two top address bits
// R18 - one transfer acknowledge per data beat
// R19 - address acknowledge with the final data beat
// R20 - error acknowledge for unsupported type, size or burst
// R21 - reset returns to idle with all strobes negated
// R22 - processor issues one transaction at a time
module burst_sram_memory_controller
  import mc_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // processor address tenure
  input  wire logic        TRANSFER_START_N_I,
  input  wire logic [31:0] ADDR_I,
  input  wire logic [4:0]  TRANSFER_TYPE_I,
  input  wire logic [2:0]  TRANSFER_SIZE_I,
  input  wire logic        BURST_INDICATOR_N_I,
  // processor acknowledges
  output logic             ADDRESS_ACK_N_O,
  output logic             TRANSFER_ACK_N_O,
  output logic             TRANSFER_ERROR_ACK_N_O,
  // sram controls
  output logic             SRAM_CHIP_ENABLE_N_O,
  output logic             SRAM_ADDRESS_STROBE_N_O,
  output logic             SRAM_BURST_ADVANCE_N_O,
  output logic             SRAM_OUTPUT_ENABLE_N_O,
  output logic [1:0]       SRAM_WORD_ADDR_O,
  // shared byte write enables
  output logic [7:0]       BYTE_WRITE_ENABLE_N_O,
  // flash and i/o controls
  output logic             FLASH_CHIP_ENABLE_N_O,
  output logic             FLASH_OUTPUT_ENABLE_N_O,
  output logic [1:0]       IO_CHIP_ENABLE_N_O,
  output logic             IO_OUTPUT_ENABLE_N_O
);
  import mc_pkg::*;

  // region from the two top address bits
  function automatic region_t region_of(input logic [31:0] addr);
    return region_t'(addr[REGION_MSB:REGION_LSB]); // [R17] [R2] [R3] [R4] [R5]
  endfunction

  // lanes touched by a single beat; size 0 means all eight
  function automatic logic [7:0] lane_mask(input logic [2:0] size, input logic [2:0] off);
    logic [3:0] n;
    logic [7:0] m;
    n = (size == SIZE_DWORD) ? 4'h8 : {1'b0, size};
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if ((i >= int'(off)) && (i < int'(off) + int'(n)))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // a beat that would spill past the doubleword cannot be served without splitting
  function automatic logic lanes_fit(input logic [2:0] size, input logic [2:0] off);
    logic [3:0] n;
    n = (size == SIZE_DWORD) ? 4'h8 : {1'b0, size};
    return ({1'b0, off} + n) <= 4'h8; // [R1]
  endfunction

  // i/o and flash latency, less the acknowledge cycle
  function automatic logic [CNT_W-1:0] slow_len(input region_t r);
    logic [CNT_W-1:0] len;
    case (r)
      REGION_FAST:  len = CNT_W'(FAST_IO_CYC - 1);  // [R3]
      REGION_SLOW:  len = CNT_W'(SLOW_IO_CYC - 1);  // [R4]
      REGION_FLASH: len = CNT_W'(FLASH_CYC - 1);    // [R5]
      default:      len = CNT_W'(1);
    endcase
    return len;
  endfunction

  // sequencer state and captured transfer attributes
  state_t     state_q;
  state_t     state_d;
  region_t    region_q;
  region_t    region_d;
  logic       wr_q;
  logic       wr_d;
  logic       burst_q;
  logic       burst_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [1:0] beat_q;
  logic [1:0] beat_d;

  // registered outputs
  logic       address_ack_n_n_q;
  logic       address_ack_n_n_d;
  logic       ta_n_q;
  logic       ta_n_d;
  logic       tea_n_q;
  logic       tea_n_d;
  logic       ce_n_q;
  logic       ce_n_d;
  logic       ads_n_q;
  logic       ads_n_d;
  logic       adv_n_q;
  logic       adv_n_d;
  logic       oe_n_q;
  logic       oe_n_d;
  logic [1:0] word_q;
  logic [1:0] word_d;
  logic [7:0] bwe_n_q;
  logic [7:0] bwe_n_d;
  logic       fcs_n_q;
  logic       fcs_n_d;
  logic       foe_n_q;
  logic       foe_n_d;
  logic [1:0] xcs_n_q;
  logic [1:0] xcs_n_d;
  logic       xoe_n_q;
  logic       xoe_n_d;

  // start-cycle decode
  region_t    start_region;
  logic       start_burst;
  logic       start_bad;
  logic       sram_busy;
  logic       slow_busy;
  logic       beat_now;

  beat_timer_if tif ();

  beat_timer u_timer (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .t       (tif.tmr)
  );

  // bus pins share this clock, so they are sampled without synchronisers
  always_comb
  begin
    start_region = region_of(ADDR_I);
    start_burst  = !BURST_INDICATOR_N_I;
    start_bad    = !TRANSFER_TYPE_I[TT_DATA_BIT]
                 || (start_burst && (start_region != REGION_SRAM))
                 || (!start_burst && !lanes_fit(TRANSFER_SIZE_I, ADDR_I[LANE_MSB:0])); // [R20]
  end

  // next-state logic
  always_comb
  begin
    state_d  = state_q;
    region_d = region_q;
    wr_d     = wr_q;
    burst_d  = burst_q;
    mask_d   = mask_q;
    beat_d   = beat_q;
    word_d   = word_q;
    tif.load = 1'b0;
    tif.len  = '0;
    case (state_q)
      ST_IDLE, ST_DESEL:
      begin
        // a start may fall in the deselect cycle, after the final acknowledge; none is queued [R14] [R22]
        state_d = ST_IDLE;
        if (!TRANSFER_START_N_I) // [R17]
        begin
          region_d = start_region;
          wr_d     = !TRANSFER_TYPE_I[TT_READ_BIT];
          burst_d  = start_burst;
          mask_d   = start_burst ? LANES_ALL : lane_mask(TRANSFER_SIZE_I, ADDR_I[LANE_MSB:0]); // [R1] [R10]
          word_d   = ADDR_I[WORD_MSB:WORD_LSB]; // [R9]
          beat_d   = start_burst ? 2'(BURST_BEATS - 1) : 2'h0; // [R2]
          if (start_bad)
          begin
            state_d = ST_ERR; // [R20]
          end
          else if (start_region == REGION_SRAM)
          begin
            state_d  = ST_SADDR; // [R8]
            tif.load = 1'b1;
            tif.len  = CNT_W'(SRAM_LEAD_CYC); // [R13]
          end
          else
          begin
            state_d  = ST_IOWAIT;
            tif.load = 1'b1;
            tif.len  = slow_len(start_region);
          end
        end
      end
      ST_SADDR:
      begin
        state_d = tif.last ? ST_SBEAT : ST_SWAIT;
      end
      ST_SWAIT:
      begin
        if (tif.last)
        begin
          state_d = ST_SBEAT; // [R13]
        end
      end
      ST_SBEAT:
      begin
        // beats follow back to back; the sram is never throttled [R13]
        if (beat_q == 2'h0)
        begin
          state_d = ST_DESEL; // [R15]
        end
        else
        begin
          beat_d = beat_q - 2'h1;
        end
      end
      ST_IOWAIT:
      begin
        if (tif.last)
        begin
          state_d = ST_IODONE;
        end
      end
      ST_IODONE:
      begin
        state_d = ST_IDLE;
      end
      ST_ERR:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // output decode from the next state so every strobe leaves a flip-flop
  always_comb
  begin
    sram_busy = (state_d == ST_SADDR) || (state_d == ST_SWAIT) || (state_d == ST_SBEAT);
    slow_busy = (state_d == ST_IOWAIT) || (state_d == ST_IODONE);
    beat_now  = (state_d == ST_SBEAT) || (state_d == ST_IODONE);

    ce_n_d  = !(state_d == ST_SADDR); // [R6] [R8] [R16]
    ads_n_d = !((state_d == ST_SADDR) || (state_d == ST_DESEL)); // [R7] [R8] [R16]
    adv_n_d = !((state_d == ST_SBEAT) && burst_d
                && (beat_d != 2'(BURST_BEATS - 1))); // [R12]
    oe_n_d  = !(sram_busy && !wr_d); // [R11]

    ta_n_d   = !beat_now; // [R18]
    address_ack_n_n_d = !(((state_d == ST_SBEAT) && (beat_d == 2'h0))
                 || (state_d == ST_IODONE) || (state_d == ST_ERR)); // [R19]
    tea_n_d  = !(state_d == ST_ERR); // [R20]

    // enables on sram data beats and for whole i/o and flash accesses, so non-write cycles leave every lane high
    bwe_n_d = (wr_d && ((state_d == ST_SBEAT) || slow_busy)) ? ~mask_d : BWE_OFF; // [R10]

    fcs_n_d    = !(slow_busy && (region_d == REGION_FLASH));
    foe_n_d    = !(slow_busy && (region_d == REGION_FLASH) && !wr_d);
    xcs_n_d[0] = !(slow_busy && (region_d == REGION_FAST));
    xcs_n_d[1] = !(slow_busy && (region_d == REGION_SLOW));
    xoe_n_d    = !(slow_busy && !wr_d
                   && ((region_d == REGION_FAST) || (region_d == REGION_SLOW)));
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_q  <= ST_IDLE; // [R21]
      region_q <= REGION_SRAM;
      wr_q     <= 1'b0;
      burst_q  <= 1'b0;
      mask_q   <= 8'h00;
      beat_q   <= 2'h0;
      word_q   <= WORD_RST;
      address_ack_n_n_q <= STROBE_OFF;
      ta_n_q   <= STROBE_OFF;
      tea_n_q  <= STROBE_OFF;
      ce_n_q   <= STROBE_OFF;
      ads_n_q  <= STROBE_OFF;
      adv_n_q  <= STROBE_OFF;
      oe_n_q   <= STROBE_OFF;
      bwe_n_q  <= BWE_OFF;
      fcs_n_q  <= STROBE_OFF;
      foe_n_q  <= STROBE_OFF;
      xcs_n_q  <= {2{STROBE_OFF}};
      xoe_n_q  <= STROBE_OFF;
    end
    else
    begin
      state_q  <= state_d;
      region_q <= region_d;
      wr_q     <= wr_d;
      burst_q  <= burst_d;
      mask_q   <= mask_d;
      beat_q   <= beat_d;
      word_q   <= word_d;
      address_ack_n_n_q <= address_ack_n_n_d;
      ta_n_q   <= ta_n_d;
      tea_n_q  <= tea_n_d;
      ce_n_q   <= ce_n_d;
      ads_n_q  <= ads_n_d;
      adv_n_q  <= adv_n_d;
      oe_n_q   <= oe_n_d;
      bwe_n_q  <= bwe_n_d;
      fcs_n_q  <= fcs_n_d;
      foe_n_q  <= foe_n_d;
      xcs_n_q  <= xcs_n_d;
      xoe_n_q  <= xoe_n_d;
    end
  end

  assign ADDRESS_ACK_N_O         = address_ack_n_n_q;
  assign TRANSFER_ACK_N_O        = ta_n_q;
  assign TRANSFER_ERROR_ACK_N_O  = tea_n_q;
  assign SRAM_CHIP_ENABLE_N_O    = ce_n_q;
  assign SRAM_ADDRESS_STROBE_N_O = ads_n_q;
  assign SRAM_BURST_ADVANCE_N_O  = adv_n_q;
  assign SRAM_OUTPUT_ENABLE_N_O  = oe_n_q;
  assign SRAM_WORD_ADDR_O        = word_q; // [R9]
  assign BYTE_WRITE_ENABLE_N_O   = bwe_n_q;
  assign FLASH_CHIP_ENABLE_N_O   = fcs_n_q;
  assign FLASH_OUTPUT_ENABLE_N_O = foe_n_q;
  assign IO_CHIP_ENABLE_N_O      = xcs_n_q;
  assign IO_OUTPUT_ENABLE_N_O    = xoe_n_q;

endmodule

// *** burst_sram_memory_controller_asserts.sv ***
// port assertions for the memory controller
module burst_sram_memory_controller_asserts
(
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        RST_N_I,
  // processor side
  input wire logic        TRANSFER_START_N_I,
  input wire logic [31:0] ADDR_I,
  input wire logic        ADDRESS_ACK_N_O,
  input wire logic        TRANSFER_ACK_N_O,
  input wire logic        TRANSFER_ERROR_ACK_N_O,
  // memory side
  input wire logic        SRAM_CHIP_ENABLE_N_O,
  input wire logic        SRAM_ADDRESS_STROBE_N_O,
  input wire logic        SRAM_BURST_ADVANCE_N_O,
  input wire logic        SRAM_OUTPUT_ENABLE_N_O,
  input wire logic [1:0]  SRAM_WORD_ADDR_O,
  input wire logic [7:0]  BYTE_WRITE_ENABLE_N_O,
  input wire logic        FLASH_CHIP_ENABLE_N_O,
  input wire logic [1:0]  IO_CHIP_ENABLE_N_O
);
  logic sram_q;
  logic sram_d;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // open sram access, so the deselect can be tied to its final acknowledge
  always_comb sram_d = !SRAM_CHIP_ENABLE_N_O ? 1'b1 : (!ADDRESS_ACK_N_O ? 1'b0 : sram_q);
  always_ff @(posedge MCLK_I or negedge RST_N_I)
    if (!RST_N_I) sram_q <= 1'b0;
    else sram_q <= sram_d;
  a_ce_with_strobe: assert property (!SRAM_CHIP_ENABLE_N_O |-> !SRAM_ADDRESS_STROBE_N_O
    && !$past(TRANSFER_START_N_I) && $past(ADDR_I[31:30]) == 2'h0) else $error("sram select mismatch");
  a_word_pos: assert property (!SRAM_CHIP_ENABLE_N_O |-> SRAM_WORD_ADDR_O == $past(ADDR_I[4:3]))
    else $error("word position wrong");
  a_deselect_after: assert property (sram_q && !ADDRESS_ACK_N_O |=>
    !SRAM_ADDRESS_STROBE_N_O && SRAM_CHIP_ENABLE_N_O) else $error("no deselect cycle");
  a_adv_three: assert property ($fell(SRAM_BURST_ADVANCE_N_O) |->
    !SRAM_BURST_ADVANCE_N_O[*3] ##1 SRAM_BURST_ADVANCE_N_O) else $error("advance length wrong");
  a_adv_no_stall: assert property (!SRAM_BURST_ADVANCE_N_O |-> !TRANSFER_ACK_N_O)
    else $error("advance without beat");
  a_sram_first: assert property ($fell(SRAM_CHIP_ENABLE_N_O) |-> TRANSFER_ACK_N_O[*2] ##1 !TRANSFER_ACK_N_O)
    else $error("sram first beat late");
  a_err_clean: assert property (!TRANSFER_ERROR_ACK_N_O |-> !ADDRESS_ACK_N_O && TRANSFER_ACK_N_O
    && SRAM_CHIP_ENABLE_N_O && FLASH_CHIP_ENABLE_N_O && IO_CHIP_ENABLE_N_O == 2'h3) else $error("error not clean");
  a_read_no_bwe: assert property (!SRAM_OUTPUT_ENABLE_N_O |-> BYTE_WRITE_ENABLE_N_O == 8'hff)
    else $error("write enable on read");
  a_fast_four: assert property ($fell(IO_CHIP_ENABLE_N_O[0]) |-> TRANSFER_ACK_N_O[*3] ##1
    (!TRANSFER_ACK_N_O && !ADDRESS_ACK_N_O)) else $error("fast io length wrong");
  a_slow_twelve: assert property ($fell(IO_CHIP_ENABLE_N_O[1]) |-> ##11
    (!TRANSFER_ACK_N_O && !ADDRESS_ACK_N_O)) else $error("slow io length wrong");
  a_flash_six: assert property ($fell(FLASH_CHIP_ENABLE_N_O) |-> TRANSFER_ACK_N_O[*5] ##1
    (!TRANSFER_ACK_N_O && !ADDRESS_ACK_N_O)) else $error("flash length wrong");
  c_burst: cover property ($fell(SRAM_BURST_ADVANCE_N_O));
  c_error: cover property (!TRANSFER_ERROR_ACK_N_O);
  c_slow: cover property ($fell(IO_CHIP_ENABLE_N_O[1]));
endmodule
bind burst_sram_memory_controller burst_sram_memory_controller_asserts burst_sram_memory_controller_asserts_inst (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .TRANSFER_START_N_I(TRANSFER_START_N_I), .ADDR_I(ADDR_I),
  .ADDRESS_ACK_N_O(ADDRESS_ACK_N_O), .TRANSFER_ACK_N_O(TRANSFER_ACK_N_O),
  .TRANSFER_ERROR_ACK_N_O(TRANSFER_ERROR_ACK_N_O), .SRAM_CHIP_ENABLE_N_O(SRAM_CHIP_ENABLE_N_O),
  .SRAM_ADDRESS_STROBE_N_O(SRAM_ADDRESS_STROBE_N_O), .SRAM_BURST_ADVANCE_N_O(SRAM_BURST_ADVANCE_N_O),
  .SRAM_OUTPUT_ENABLE_N_O(SRAM_OUTPUT_ENABLE_N_O), .SRAM_WORD_ADDR_O(SRAM_WORD_ADDR_O),
  .BYTE_WRITE_ENABLE_N_O(BYTE_WRITE_ENABLE_N_O), .FLASH_CHIP_ENABLE_N_O(FLASH_CHIP_ENABLE_N_O),
  .IO_CHIP_ENABLE_N_O(IO_CHIP_ENABLE_N_O));

// *** burst_sram_memory_controller_bench.sv ***
// self-checking bench for the memory controller
module burst_sram_memory_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mc_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        ts_n;
  logic [31:0] addr;
  logic [4:0]  tt;
  logic [2:0]  tsz;
  logic        tb_n;
  logic        address_ack_n_n;
  logic        ta_n;
  logic        tea_n;
  logic        sce_n;
  logic        sads_n;
  logic        sadv_n;
  logic        soe_n;
  logic [1:0]  word;
  logic [7:0]  bwe_n;
  logic        fce_n;
  logic        foe_n;
  logic [1:0]  ioce_n;
  logic        iooe_n;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [31:0] seed = 32'h51e25172;
  logic [16:0] notes[$];
  logic        busy = 1'b0;
  int          cnt;
  int          tas;
  logic        rd;
  logic [16:0] got;
  logic [16:0] want;
  logic [21:0] rst_v;
  burst_sram_memory_controller burst_sram_memory_controller_inst (.MCLK_I(mclk), .RST_N_I(rst_n),
    .TRANSFER_START_N_I(ts_n), .ADDR_I(addr), .TRANSFER_TYPE_I(tt), .TRANSFER_SIZE_I(tsz),
    .BURST_INDICATOR_N_I(tb_n), .ADDRESS_ACK_N_O(address_ack_n_n), .TRANSFER_ACK_N_O(ta_n),
    .TRANSFER_ERROR_ACK_N_O(tea_n), .SRAM_CHIP_ENABLE_N_O(sce_n), .SRAM_ADDRESS_STROBE_N_O(sads_n),
    .SRAM_BURST_ADVANCE_N_O(sadv_n), .SRAM_OUTPUT_ENABLE_N_O(soe_n), .SRAM_WORD_ADDR_O(word),
    .BYTE_WRITE_ENABLE_N_O(bwe_n), .FLASH_CHIP_ENABLE_N_O(fce_n), .FLASH_OUTPUT_ENABLE_N_O(foe_n),
    .IO_CHIP_ENABLE_N_O(ioce_n), .IO_OUTPUT_ENABLE_N_O(iooe_n));
  cpu_bus_model cpu_bus_model_inst (.clk_i(mclk), .start_n_o(ts_n), .addr_o(addr), .type_o(tt),
    .size_o(tsz), .burst_n_o(tb_n), .address_ack_n_n_i(address_ack_n_n));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // note: read strobe seen, error flag, beat count, cycles to final acknowledge, write enables then
  function automatic logic [16:0] expect_of(input logic [31:0] a, input logic [4:0] t,
                                            input logic [2:0] s, input logic b);
    logic [3:0] len;
    logic [7:0] m;
    logic [3:0] lat;
    len = (s == 3'h0) ? 4'h8 : {1'b0, s};
    m = b ? 8'(((16'h1 << len) - 16'h1) << a[2:0]) : 8'hff;
    lat = (a[31:30] == 2'h0) ? (b ? 4'h3 : 4'h6) : (a[31:30] == 2'h1) ? 4'h4 : (a[31:30] == 2'h2) ? 4'hc : 4'h6;
    if (!t[TT_DATA_BIT] || (!b && a[31:30] != 2'h0) || (b && {1'b0, a[2:0]} + len > 4'h8))
      return {1'b0, 1'b1, 3'h0, 4'h1, 8'hff};
    return {t[TT_READ_BIT], 1'b0, b ? 3'h1 : 3'h4, lat, t[TT_READ_BIT] ? 8'hff : ~m};
  endfunction
  task automatic go(input logic [31:0] a, input logic [4:0] t, input logic [2:0] s, input logic b);
    notes.push_back(expect_of(a, t, s, b));
    cpu_bus_model_inst.run(a, t, s, b);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    if (!busy && ts_n === 1'b0)
    begin
      busy = 1'b1;
      cnt = 0;
      tas = 0;
      rd = 1'b0;
    end
    else if (busy)
    begin
      cnt++;
      if (ta_n === 1'b0) tas++;
      if (soe_n === 1'b0 || foe_n === 1'b0 || iooe_n === 1'b0) rd = 1'b1;
      if (address_ack_n_n === 1'b0)
      begin
        busy = 1'b0;
        got = {rd, ~tea_n, 3'(tas), 4'(cnt), bwe_n};
        want = (notes.size() > 0) ? notes.pop_front() : 'x;
        n_compared++;
        if (got !== want)
        begin
          $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
          num_errors++;
        end
      end
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #(50 * 5000);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    n_compared++;
    rst_v = {address_ack_n_n, ta_n, tea_n, sce_n, sads_n, sadv_n, soe_n, fce_n, foe_n, ioce_n, iooe_n, bwe_n, word};
    if (rst_v !== 22'h3ffffc)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, rst_v, 22'h3ffffc);
      num_errors++;
    end
    #5;
    rst_n = 1'b1;
    for (int r = 0; r < 4; r++)
      for (int w = 0; w < 2; w++)
        go({2'(r), 30'h18}, w ? 5'h0a : 5'h02, 3'h0, 1'b1);
    go(32'h0000_0010, 5'h0a, 3'h0, 1'b0);
    go(32'h0000_0008, 5'h02, 3'h0, 1'b0);
    go(32'hc000_0000, 5'h0a, 3'h0, 1'b0);
    go(32'h4000_0006, 5'h02, 3'h4, 1'b1);
    go(32'h0000_0000, 5'h08, 3'h0, 1'b1);
    repeat (40)
    begin
      seed = xs(seed);
      go(seed, {1'b0, seed[5], 1'b0, seed[6] | seed[7], 1'b0}, seed[10:8], seed[11] | seed[12]);
    end
    repeat (3) @(posedge mclk);
    if (notes.size() != 0)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, notes.size(), 0);
      num_errors++;
    end
    report_and_stop();
  end
endmodule

// *** cpu_bus_model.sv ***
// processor model issuing one bus transaction at a time
module cpu_bus_model
(
  // clock
  input  wire logic   clk_i,
  // address tenure
  output logic        start_n_o,
  output logic [31:0] addr_o,
  output logic [4:0]  type_o,
  output logic [2:0]  size_o,
  output logic        burst_n_o,
  // final acknowledge
  input  wire logic   address_ack_n_n_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    start_n_o = 1'b1;
    addr_o = 32'h0;
    type_o = 5'h0;
    size_o = 3'h0;
    burst_n_o = 1'b1;
  end
  task automatic run(input logic [31:0] a, input logic [4:0] t, input logic [2:0] s, input logic b);
    int n;
    n = 0;
    @(posedge clk_i);
    #5;
    start_n_o = 1'b0;
    addr_o = a;
    type_o = t;
    size_o = s;
    burst_n_o = b;
    @(posedge clk_i);
    #5;
    start_n_o = 1'b1;
    while (address_ack_n_n_i !== 1'b0 && n < 40)
    begin
      @(posedge clk_i);
      #5;
      n++;
    end
    // released address, type and size lines must not keep showing the old request
    addr_o = ~a;
    type_o = ~t;
    size_o = ~s;
  endtask
endmodule

// *** mc_pkg.sv ***
// constants and types shared by the memory controller files
package mc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SRAM_DECODE_NS = 10;
  localparam int SRAM_DECODE_CYC_RAW = (SRAM_DECODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRAM_DECODE_CYC = (SRAM_DECODE_CYC_RAW < 1) ? 1 : SRAM_DECODE_CYC_RAW;
  localparam int SRAM_FIRST_CYC  = 3;
  localparam int SRAM_LEAD_CYC   = (SRAM_FIRST_CYC - 1 > SRAM_DECODE_CYC) ? SRAM_FIRST_CYC - 1
                                                                          : SRAM_DECODE_CYC + 1;
  localparam int BURST_BEATS     = 4;
  localparam int FAST_IO_CYC     = 4;
  localparam int SLOW_IO_CYC     = 12;
  localparam int FLASH_CYC       = 6;
  localparam int CNT_W           = 4;

  // address fields, little-endian bit numbering
  localparam int REGION_MSB = 31;
  localparam int REGION_LSB = 30;
  localparam int WORD_MSB   = 4;
  localparam int WORD_LSB   = 3;
  localparam int LANE_MSB   = 2;

  // transfer type bits
  localparam int TT_DATA_BIT = 1;
  localparam int TT_READ_BIT = 3;

  // transfer size code meaning eight bytes
  localparam logic [2:0] SIZE_DWORD = 3'h0;

  // reset and idle values
  localparam logic       STROBE_OFF = 1'b1;
  localparam logic [7:0] BWE_OFF    = 8'hff;
  localparam logic [7:0] LANES_ALL  = 8'hff;
  localparam logic [1:0] WORD_RST   = 2'h0;

  typedef enum logic [1:0] {
    REGION_SRAM  = 2'h0,
    REGION_FAST  = 2'h1,
    REGION_SLOW  = 2'h2,
    REGION_FLASH = 2'h3
  } region_t;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_SADDR  = 8'h02,
    ST_SWAIT  = 8'h04,
    ST_SBEAT  = 8'h08,
    ST_DESEL  = 8'h10,
    ST_IOWAIT = 8'h20,
    ST_IODONE = 8'h40,
    ST_ERR    = 8'h80
  } state_t;

endpackage
